// ==== design/panel_adapter.sv ====
`include "panel_adapter_defs.svh"

// How it works
// - Setup bits 12:4 hold pixels per row minus one; it ends each line.
// - Setup bit 0: one selects conversion mode, zero selects bypass.
// - Override bit 9 forces mode output to bit 8, else automatic rise.
// - Mode delay 13:12 is row-reset rising edges minus one before rise.
// - Bypass: control bit 4 drives the panel supply output.
// - Bypass: control bit 3 drives the panel display-enable output.
// - Conversion: control bit 1 gates the gate-driver clock output.
// - Conversion: control bit 0 gates the row-reset output.
// - Bypass: gate and row enable bits read back as zero.
// - Delays count pixel-clock periods; mode delay counts row-reset edges.
// - Timing one 11:8: reversal leading edge delay, periods minus one.
// - Timing one 7:4: reversal falling edge delay, periods minus one.
// - Timing one 3:0: line pulse output delay, periods minus one.
// - Timing two 15:9: start pulse delay during vertical porches.
// - Timing two 8:0: delay from start pulse to gate and power-save trail.
// - Conversion reshapes line timing; power sequencing follows the core.
// - Reserved bits read as zero; software writes back reset values.
module panel_adapter #(
  parameter int CNT_W = 10                    // Line counter width
) (
  input  wire logic                         pclk,       // Bus clock
  input  wire logic                         presetn,    // Async reset
  input  wire logic                         psel,       // APB select
  input  wire logic                         penable,    // APB enable
  input  wire logic                         pwrite,     // APB write
  input  wire panel_adapter_pkg::apb_addr_t paddr,      // APB address
  input  wire logic [31:0]                  pwdata,     // APB write data
  output logic      [31:0]                  prdata,     // APB read data
  output logic                              pready,     // APB ready
  output logic                              pslverr,    // APB error
  input  wire logic                         pixel_clock, // Pixel clock
  input  wire logic                         core_line_pulse, // Core line
  input  wire logic                         core_frame_pulse, // Core frame
  input  wire logic                         core_porch, // Vertical porch
  input  wire logic                         core_power, // Core power seq
  output logic                              line_pulse, // Line pulse pin
  output logic                              start_pulse_out, // Start pulse
  output logic                              polarity_reversal_out, // REV
  output logic                              gate_clock_out, // Gate clock
  output logic                              power_save_out, // Power save
  output logic                              row_reset_out, // Row reset
  output logic                              panel_mode_out, // Mode output
  output logic                              panel_supply_out, // Supply en
  output logic                              panel_on_out // Display enable
);
  import panel_adapter_pkg::*;

  if (CNT_W < 10 || CNT_W > 16) begin : g_cnt_w_check
    $error("CNT_W must lie in 10..16");
  end

  // ==========================================================
  // Helpers
  function automatic logic hit(input logic [CNT_W-1:0] c,
                               input logic [8:0] f);
    hit = (c == {{(CNT_W-9){1'b0}}, f});
  endfunction : hit

  // ==========================================================
  // Register file
  logic [31:0] setup_r, ctrl_r, tim1_r, tim2_r;
  logic [31:0] rd_data_r;
  logic        rd_err_r;

  wire         setup_ph  = psel & ~penable;
  wire         wr_acc    = psel & penable & pwrite;
  wire         sel_setup = (paddr == `PA_OFF_SETUP);
  wire         sel_ctrl  = (paddr == `PA_OFF_CTRL);
  wire         sel_tim1  = (paddr == `PA_OFF_TIM1);
  wire         sel_tim2  = (paddr == `PA_OFF_TIM2);
  wire         unmapped  = (paddr >= `PA_OFF_LIMIT) |
                           (paddr[1:0] != 2'b00);
  wire         conv      = setup_r[`PA_CONV_BIT];
  wire [31:0]  ctrl_rd   = conv ? ctrl_r :
                           (ctrl_r & ~((32'h1 << `PA_GATE_BIT) |
                                       (32'h1 << `PA_ROW_BIT)));
  wire [31:0]  rd_mux;

  // Read selection; reserved bits are never stored
  assign rd_mux = sel_setup ? setup_r :
                  sel_ctrl  ? ctrl_rd :
                  sel_tim1  ? tim1_r :
                  sel_tim2  ? tim2_r : `PA_RD_ZERO;

  // Writes land at the access-phase edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_r <= `PA_SETUP_RST;
      ctrl_r  <= `PA_CTRL_RST;
      tim1_r  <= `PA_TIM1_RST;
      tim2_r  <= `PA_TIM2_RST;
    end else if (wr_acc && !unmapped) begin
      if (sel_setup) begin
        setup_r <= pwdata & `PA_SETUP_MASK;
      end else if (sel_ctrl) begin
        ctrl_r <= pwdata & `PA_CTRL_MASK;
      end else if (sel_tim1) begin
        tim1_r <= pwdata & `PA_TIM1_MASK;
      end else if (sel_tim2) begin
        tim2_r <= pwdata & `PA_TIM2_MASK;
      end
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_r <= `PA_RD_ZERO;
      rd_err_r  <= 1'b0;
    end else if (setup_ph) begin
      rd_data_r <= pwrite ? `PA_RD_ZERO : rd_mux;
      rd_err_r  <= unmapped;
    end
  end

  assign prdata  = rd_data_r;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & rd_err_r;

  // ==========================================================
  // Field views
  wire [8:0] ppr_f   = setup_r[`PA_PPR_HI:`PA_PPR_LO];
  wire [1:0] md_f    = tim1_r[`PA_MD_HI:`PA_MD_LO];
  wire [8:0] lead_f  = {5'h00, tim1_r[`PA_LEAD_HI:`PA_LEAD_LO]};
  wire [8:0] fall_f  = {5'h00, tim1_r[`PA_FALL_HI:`PA_FALL_LO]};
  wire [8:0] lpd_f   = {5'h00, tim1_r[`PA_LPD_HI:`PA_LPD_LO]};
  wire [8:0] spl_f   = {2'b00, tim2_r[`PA_SPL_HI:`PA_SPL_LO]};
  wire [8:0] trl_f   = tim2_r[`PA_TRL_HI:`PA_TRL_LO];
  wire       ovr     = ctrl_r[`PA_OVR_BIT];
  wire       fval    = ctrl_r[`PA_FVAL_BIT];
  wire       gate_en = conv & ctrl_r[`PA_GATE_BIT];
  wire       row_en  = conv & ctrl_r[`PA_ROW_BIT];

  // ==========================================================
  // Input synchronisers: a change counts when stages 2 and 3 agree
  logic [`PA_NSYNC-1:0] s1_r, s2_r, s3_r, st_r, st_q_r;
  wire  [`PA_NSYNC-1:0] in_w = {core_power, core_porch,
                                core_frame_pulse, core_line_pulse,
                                pixel_clock};
  wire  [`PA_NSYNC-1:0] agree = ~(s2_r ^ s3_r);
  wire  [`PA_NSYNC-1:0] st_nxt = (agree & s3_r) | (~agree & st_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      st_r   <= '0;
      st_q_r <= '0;
    end else begin
      s1_r   <= in_w;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      st_r   <= st_nxt;
      st_q_r <= st_r;
    end
  end

  wire pix_rise = st_r[`PA_S_PIX] & ~st_q_r[`PA_S_PIX];
  wire lp_st    = st_r[`PA_S_LP];
  wire lp_rise  = lp_st & ~st_q_r[`PA_S_LP];
  wire frm_st   = st_r[`PA_S_FRM];
  wire porch_st = st_r[`PA_S_PORCH];
  wire pwr_st   = st_r[`PA_S_PWR];

  // ==========================================================
  // Line engine: counts pixel periods from the line reference
  line_state_t        lstate_r;
  logic [CNT_W-1:0]   cnt_r;
  logic               trun_r;
  logic [8:0]         tcnt_r;

  wire tick    = pix_rise & (lstate_r == line_run_s);
  wire ev_lp   = tick & hit(cnt_r, lpd_f);
  wire ev_lead = tick & hit(cnt_r, lead_f);
  wire ev_fall = tick & hit(cnt_r, fall_f);
  wire ev_spl  = tick & hit(cnt_r, spl_f);
  wire ev_end  = tick & hit(cnt_r, ppr_f);
  wire ev_trl  = pix_rise & trun_r & (tcnt_r == trl_f);

  // Line state and counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lstate_r <= line_idle_s;
      cnt_r    <= '0;
    end else begin
      case (lstate_r)
        line_idle_s: begin
          if (conv && lp_rise) begin
            lstate_r <= line_run_s;
            cnt_r    <= '0;
          end
        end
        line_run_s: begin
          if (!conv || ev_end) begin
            lstate_r <= line_idle_s;
          end else if (tick) begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: lstate_r <= line_idle_s;
      endcase
    end
  end

  // Trail counter started by the start-pulse moment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trun_r <= 1'b0;
      tcnt_r <= '0;
    end else if (!conv || ev_trl) begin
      trun_r <= 1'b0;
    end else if (ev_spl) begin
      trun_r <= 1'b1;
      tcnt_r <= '0;
    end else if (pix_rise && trun_r) begin
      tcnt_r <= tcnt_r + 1'b1;
    end
  end

  // ==========================================================
  // Panel timing outputs
  logic lp_r, sp_r, rev_r, gate_r, ps_r, row_r, row_q_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_r  <= 1'b0;
      sp_r  <= 1'b0;
      rev_r <= 1'b0;
    end else if (!conv) begin
      lp_r  <= lp_st;
      sp_r  <= frm_st;
      rev_r <= 1'b0;
    end else begin
      if (ev_lp || (tick && lp_r)) begin
        lp_r <= ev_lp;
      end
      if (ev_spl || (tick && sp_r)) begin
        sp_r <= ev_spl & porch_st;
      end
      if (ev_lead) begin
        rev_r <= 1'b1;
      end else if (ev_fall) begin
        rev_r <= 1'b0;
      end
    end
  end

  // Gate clock and power save: lead and trail edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_r <= 1'b0;
      ps_r   <= 1'b0;
    end else if (!conv) begin
      gate_r <= 1'b0;
      ps_r   <= 1'b0;
    end else begin
      if (ev_trl) begin
        gate_r <= 1'b0;
        ps_r   <= 1'b0;
      end else if (ev_lead) begin
        gate_r <= gate_en;
        ps_r   <= 1'b1;
      end
      if (!gate_en) begin
        gate_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Row reset, mode sequencing and power outputs
  logic [1:0] rr_cnt_r;
  logic       auto_mode_r, mode_r, sup_r, on_r;
  wire        row_rise = row_r & ~row_q_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_r   <= 1'b0;
      row_q_r <= 1'b0;
    end else begin
      row_r   <= row_en & frm_st;
      row_q_r <= row_r;
    end
  end

  // Counts row-reset rising edges before the mode output rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rr_cnt_r    <= 2'b00;
      auto_mode_r <= 1'b0;
    end else if (!conv) begin
      rr_cnt_r    <= 2'b00;
      auto_mode_r <= 1'b0;
    end else if (row_rise && !auto_mode_r) begin
      if (rr_cnt_r == md_f) begin
        auto_mode_r <= 1'b1;
      end else begin
        rr_cnt_r <= rr_cnt_r + 2'b01;
      end
    end
  end

  // Mode, supply and display-enable output registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= 1'b0;
      sup_r  <= 1'b0;
      on_r   <= 1'b0;
    end else begin
      mode_r <= ovr ? fval : auto_mode_r;
      sup_r  <= conv ? pwr_st : ctrl_r[`PA_SUP_BIT];
      on_r   <= conv ? pwr_st : ctrl_r[`PA_ON_BIT];
    end
  end

  assign line_pulse            = lp_r;
  assign start_pulse_out       = sp_r;
  assign polarity_reversal_out = rev_r;
  assign gate_clock_out        = gate_r;
  assign power_save_out        = ps_r;
  assign row_reset_out         = row_r;
  assign panel_mode_out        = mode_r;
  assign panel_supply_out      = sup_r;
  assign panel_on_out          = on_r;

  // ==========================================================
  // Assertions
  property p_override;
    @(posedge pclk) disable iff (!presetn)
      ovr |=> (panel_mode_out == $past(fval));
  endproperty
  a_override: assert property (p_override)
    else $error("mode output ignores override");
  property p_supply;
    @(posedge pclk) disable iff (!presetn)
      !conv |=> (panel_supply_out == $past(ctrl_r[`PA_SUP_BIT]));
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply output does not follow control");
  property p_on;
    @(posedge pclk) disable iff (!presetn)
      !conv |=> (panel_on_out == $past(ctrl_r[`PA_ON_BIT]));
  endproperty
  a_on: assert property (p_on)
    else $error("display enable does not follow control");
  property p_gate_off;
    @(posedge pclk) disable iff (!presetn)
      !gate_en |=> !gate_clock_out;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("gate clock active while disabled");
  property p_row_off;
    @(posedge pclk) disable iff (!presetn)
      !row_en |=> !row_reset_out;
  endproperty
  a_row_off: assert property (p_row_off)
    else $error("row reset active while disabled");
  property p_rd_mask;
    @(posedge pclk) disable iff (!presetn)
      (setup_ph && !pwrite && sel_ctrl && !conv) |=> (prdata[1:0] == 2'b00);
  endproperty
  a_rd_mask: assert property (p_rd_mask)
    else $error("enable bits visible in bypass");
  property p_lp_delay;
    @(posedge pclk) disable iff (!presetn)
      (ev_lp && conv) |=> line_pulse;
  endproperty
  a_lp_delay: assert property (p_lp_delay)
    else $error("line pulse missing after delay");
  property p_bypass_lp;
    @(posedge pclk) disable iff (!presetn)
      !conv |=> (line_pulse == $past(lp_st));
  endproperty
  a_bypass_lp: assert property (p_bypass_lp)
    else $error("bypass line pulse not passed");
  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
      (setup_ph && unmapped) |=> (pslverr && prdata == `PA_RD_ZERO);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_mode_auto;
    @(posedge pclk) disable iff (!presetn)
      (!ovr && conv && !auto_mode_r) |=> !panel_mode_out;
  endproperty
  a_mode_auto: assert property (p_mode_auto)
    else $error("mode output rose early");

endmodule : panel_adapter

// ==== design/panel_adapter_defs.svh ====
`ifndef PANEL_ADAPTER_DEFS_SVH
`define PANEL_ADAPTER_DEFS_SVH

// ==========================================================
// Register offsets (byte addresses in the 4 KB window)
`define PA_OFF_SETUP    12'h000
`define PA_OFF_CTRL     12'h004
`define PA_OFF_TIM1     12'h008
`define PA_OFF_TIM2     12'h00C
`define PA_OFF_LIMIT    12'h010

// ==========================================================
// Writable bits and reset values
`define PA_SETUP_MASK   32'h0000_1FF1
`define PA_CTRL_MASK    32'h0000_031B
`define PA_TIM1_MASK    32'h0000_3FFF
`define PA_TIM2_MASK    32'h0000_FFFF
`define PA_SETUP_RST    32'h0000_0000
`define PA_CTRL_RST     32'h0000_0000
`define PA_TIM1_RST     32'h0000_1000
`define PA_TIM2_RST     32'h0000_0000
`define PA_RD_ZERO      32'h0000_0000

// ==========================================================
// Field positions
`define PA_CONV_BIT     0
`define PA_PPR_HI       12
`define PA_PPR_LO       4
`define PA_OVR_BIT      9
`define PA_FVAL_BIT     8
`define PA_SUP_BIT      4
`define PA_ON_BIT       3
`define PA_GATE_BIT     1
`define PA_ROW_BIT      0
`define PA_MD_HI        13
`define PA_MD_LO        12
`define PA_LEAD_HI      11
`define PA_LEAD_LO      8
`define PA_FALL_HI      7
`define PA_FALL_LO      4
`define PA_LPD_HI       3
`define PA_LPD_LO       0
`define PA_SPL_HI       15
`define PA_SPL_LO       9
`define PA_TRL_HI       8
`define PA_TRL_LO       0

// ==========================================================
// Input synchroniser lanes
`define PA_NSYNC        5
`define PA_S_PIX        0
`define PA_S_LP         1
`define PA_S_FRM        2
`define PA_S_PORCH      3
`define PA_S_PWR        4

`endif

// ==== design/panel_adapter_pkg.sv ====
`include "panel_adapter_defs.svh"

package panel_adapter_pkg;

  // ==========================================================
  // Types
  typedef logic [11:0] apb_addr_t;
  typedef enum logic {line_idle_s, line_run_s} line_state_t;

endpackage : panel_adapter_pkg

// ==== dv/core_timing_model.sv ====
// ==========================================================
// Controller core side: pixel clock, line, frame, porch, power
module core_timing_model (
  output logic pixel_clock,      // Pixel clock, still outside lines
  output logic core_line_pulse,  // Internal line pulse
  output logic core_frame_pulse, // Frame pulse, source of row reset
  output logic core_porch,       // High in vertical porches
  output logic core_power        // Power sequencing level
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle levels at time zero
  initial begin
    {pixel_clock, core_line_pulse, core_frame_pulse} = 3'b000;
    {core_porch, core_power} = 2'b00;
  end

  // One line of n 400 ns pixel periods; the line rises just after an
  // uncounted pixel edge so the adapter never misses the first edge
  task automatic line(input int n, input logic porch);
    core_porch = porch;
    #7 pixel_clock = 1'b1;
    #20 core_line_pulse = 1'b1;
    #180 pixel_clock = 1'b0;
    repeat (n) begin
      #200 pixel_clock = 1'b1;
      #200 pixel_clock = 1'b0;
    end
    core_line_pulse = 1'b0;
    core_porch = 1'b0;
    #400;
  endtask : line

  // One frame pulse of 1 us, off the bus edge, then 1 us quiet
  task automatic frame();
    #7 core_frame_pulse = 1'b1;
    #1000 core_frame_pulse = 1'b0;
    #1000;
  endtask : frame

  // Vertical power level, as a standard panel would get it
  task automatic set_power(input logic v);
    #7 core_power = v;
  endtask : set_power
endmodule : core_timing_model

// ==== dv/tb.sv ====
// ==========================================================
// Register and timing checks of the panel adapter
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import panel_adapter_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite;
  apb_addr_t   paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, pixel_clock, core_line_pulse;
  logic        core_frame_pulse, core_porch, core_power;
  logic        line_pulse, start_pulse_out, polarity_reversal_out;
  logic        gate_clock_out, power_save_out, row_reset_out;
  logic        panel_mode_out, panel_supply_out, panel_on_out;
  logic [4:0]  o_d;
  logic        pix_d, lin_d;
  int          fails, n_compared, pcnt, g_n, g0;
  int          c_lp, c_rr, c_rf, c_gr, c_sp, c_pf;
  wire  [4:0]  outs = {line_pulse, polarity_reversal_out, gate_clock_out,
                       start_pulse_out, power_save_out};

  panel_adapter #(.CNT_W(10)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixel_clock(pixel_clock), .core_line_pulse(core_line_pulse),
    .core_frame_pulse(core_frame_pulse), .core_porch(core_porch),
    .core_power(core_power), .line_pulse(line_pulse),
    .start_pulse_out(start_pulse_out),
    .polarity_reversal_out(polarity_reversal_out),
    .gate_clock_out(gate_clock_out), .power_save_out(power_save_out),
    .row_reset_out(row_reset_out), .panel_mode_out(panel_mode_out),
    .panel_supply_out(panel_supply_out), .panel_on_out(panel_on_out));

  core_timing_model i_core (.pixel_clock(pixel_clock),
    .core_line_pulse(core_line_pulse), .core_frame_pulse(core_frame_pulse),
    .core_porch(core_porch), .core_power(core_power));

  // Pixel edges since line start, noted at the output edges the line test checks
  always @(posedge pclk) begin
    pix_d <= pixel_clock;
    lin_d <= core_line_pulse;
    o_d   <= outs;
    if (core_line_pulse && !lin_d) pcnt <= 0;
    else if (pixel_clock && !pix_d) pcnt <= pcnt + 1;
    if (outs[4] && !o_d[4]) c_lp <= pcnt;
    if (outs[3] && !o_d[3]) c_rr <= pcnt;
    if (!outs[3] && o_d[3]) c_rf <= pcnt;
    if (outs[2] && !o_d[2]) c_gr <= pcnt;
    if (outs[2] && !o_d[2]) g_n <= g_n + 1;
    if (outs[1] && !o_d[1]) c_sp <= pcnt;
    if (!outs[0] && o_d[0]) c_pf <= pcnt;
  end

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input apb_addr_t a,
                     input logic [31:0] wd, output logic [31:0] r,
                     output logic e);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        r = prdata;
        e = pslverr;
        break;
      end
    end
    {psel, penable} <= 2'b00;
    if (k == 20) begin
      fails++;
      $display("[ERR] %0t no ready", $time);
      finish_test();
    end
  endtask : apb

  task automatic wr(input apb_addr_t a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input apb_addr_t a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // Watchdog against a hang
  initial begin
    #1ms;
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {pix_d, lin_d, o_d, pcnt, g_n} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0, 1'b0);
    rd(12'h004, 32'h0, 1'b0);
    rd(12'h008, 32'h0000_1000, 1'b0);
    rd(12'h00C, 32'h0, 1'b0);
    rd(12'h010, 32'h0, 1'b1);
    done("reset");
    // Core idle here, so the mode may change
    wr(12'h000, 32'hFFFF_FFFF);
    rd(12'h000, 32'h0000_1FF1, 1'b0);
    wr(12'h004, 32'hFFFF_FFFF);
    rd(12'h004, 32'h0000_031B, 1'b0);
    wr(12'h008, 32'hFFFF_FFFF);
    rd(12'h008, 32'h0000_3FFF, 1'b0);
    wr(12'h00C, 32'hFFFF_FFFF);
    rd(12'h00C, 32'h0000_FFFF, 1'b0);
    wr(12'h000, 32'h0);
    rd(12'h004, 32'h0000_0318, 1'b0);
    done("access");
    wr(12'h004, 32'h18);
    repeat (4) @(posedge pclk);
    chk(panel_supply_out, 1'b1);
    chk(panel_on_out, 1'b1);
    wr(12'h004, 32'h300);
    repeat (4) @(posedge pclk);
    chk(panel_supply_out, 1'b0);
    chk(panel_on_out, 1'b0);
    chk(panel_mode_out, 1'b1);
    wr(12'h004, 32'h200);
    repeat (4) @(posedge pclk);
    chk(panel_mode_out, 1'b0);
    fork
      i_core.line(24, 1'b0);
      begin
        repeat (20) @(posedge pclk);
        chk(line_pulse, 1'b1);
        chk(polarity_reversal_out, 1'b0);
      end
    join
    done("bypass");
    // All delays above zero, start delay above sync plus porch
    wr(12'h008, 32'h0000_1362);
    wr(12'h00C, 32'h0000_0802);
    wr(12'h000, 32'h0000_0141);
    wr(12'h004, 32'h3);
    fork
      i_core.frame();
      begin
        repeat (10) @(posedge pclk);
        chk(row_reset_out, 1'b1);
      end
    join
    chk(panel_mode_out, 1'b0);
    i_core.frame();
    chk(panel_mode_out, 1'b1);
    wr(12'h004, 32'h2);
    fork
      i_core.frame();
      begin
        repeat (10) @(posedge pclk);
        chk(row_reset_out, 1'b0);
      end
    join
    i_core.set_power(1'b1);
    repeat (8) @(posedge pclk);
    chk(panel_supply_out, 1'b1);
    done("vertical");
    wr(12'h004, 32'h3);
    i_core.line(24, 1'b1);
    chk(c_lp, 3);
    chk(c_rr, 4);
    chk(c_rf, 7);
    chk(c_gr, 4);
    chk(c_sp, 5);
    chk(c_pf, 8);
    wr(12'h004, 32'h1);
    g0 = g_n;
    i_core.line(24, 1'b1);
    chk(g_n - g0, 0);
    chk(c_lp, 3);
    done("line");
    finish_test();
  end
endmodule : tb
